// >>> logic/dspo_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset; DEPTH is a power of two.
`timescale 1ns/1ps
module dspo_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // System clock
  input  wire logic             rst,       // Synchronous reset
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Space available
  input  wire logic [WIDTH-1:0] in_data,   // Write word
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Read acknowledge
  output logic [WIDTH-1:0]      out_data,  // Head word
  output logic                  full,      // No space left
  output logic                  empty      // Nothing stored
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign full      = (count == (PW+1)'(DEPTH));
  assign empty     = (count == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      if (do_wr && !do_rd) begin
        count <= count + (PW+1)'(1);
      end else if (do_rd && !do_wr) begin
        count <= count - (PW+1)'(1);
      end
    end
  end

endmodule : dspo_fifo

// >>> logic/dspo_pkg.sv
// Constants for the parallel pixel output and general-purpose pin block.
// Assumes a 100 MHz system clock and an AXI4-Lite register master.
package dspo_pkg;

  // Geometry
  localparam int PIX_W     = 12;
  localparam int PIX10_W   = 10;
  localparam int WORD_W    = 14;
  localparam int FIFO_DEPTH = 16;
  localparam int GPIO_N    = 4;
  localparam int ADDR_W    = 8;

  // Bits of a buffered word
  localparam int WORD_LINE_BIT  = 12;
  localparam int WORD_FRAME_BIT = 13;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_DIR = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_OUT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h0C;

  // Control register fields and reset values
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_EN_BIT   = 3;
  localparam logic       CTRL_EDGE_RESET = 1'h1;
  localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
  localparam logic       CTRL_EN_RESET   = 1'h1;
  localparam logic [3:0] GPIO_DIR_RESET  = 4'h0;
  localparam logic [3:0] GPIO_OUT_RESET  = 4'h0;

  // Status register fields
  localparam int STAT_PIN_LSB    = 0;
  localparam int STAT_EXTOSC_BIT = 4;
  localparam int STAT_EMPTY_BIT  = 5;
  localparam int STAT_FULL_BIT   = 6;
  localparam int STAT_UNDER_BIT  = 7;
  localparam int STAT_LVIOL_BIT  = 8;
  localparam int STAT_FVIOL_BIT  = 9;

  // Upper pin pair, forced to output under an external oscillator
  localparam logic [3:0] GPIO_UPPER_MASK = 4'hC;

  // Output modes
  typedef enum logic [1:0] {
    DSPO_MODE_12LF,
    DSPO_MODE_12HF,
    DSPO_MODE_10
  } dspo_mode_t;

  // Timing
  localparam int SYS_PERIOD_NS  = 10;
  localparam int PCLK_PERIOD_NS = 40;
  localparam int PCLK_DIV       = PCLK_PERIOD_NS / SYS_PERIOD_NS;
  localparam int PCLK_HALF      = PCLK_DIV / 2;
  localparam int SYNC_MIN_PIX   = 10;
  localparam logic [3:0] GAP_MAX = 4'hF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dspo_pkg

// >>> logic/dspo_top.sv
// Parallel pixel output stage with general-purpose pin direction control.
// Assumes link-side pixel words arrive from logic on CLK_SYS; pins are asynchronous.
// What this block does
// - In both 12-bit modes line and frame sync pass through unfiltered.
// - A control bit picks which pixel clock edge strobes the output data.
// - Each lower pin is either an input forwarded to the remote side or a register output.
// - Each upper pin is either an input forwarded to the remote side or a register output.
// - With an external oscillator the upper pins can only be register-driven outputs.
// - In 10-bit mode the pixel clock lies in 25 to 100 MHz with ten data bits and two syncs.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module dspo_top (
  input  wire logic        CLK_SYS,               // 100 MHz system clock
  input  wire logic        RESET,                 // Synchronous reset, active high
  input  wire logic [11:0] LINK_PIX_DATA,         // Recovered pixel word
  input  wire logic        LINK_LINE_SYNC,        // Recovered line sync
  input  wire logic        LINK_FRAME_SYNC,       // Recovered frame sync
  input  wire logic        LINK_VALID,            // Pixel word offered
  output logic             LINK_READY,            // Buffer has room
  output logic             PIXEL_CLK,             // Pixel clock output
  output logic [11:0]      PIXEL_DATA_OUT,        // Parallel pixel data
  output logic             LINE_SYNC,             // Line sync output
  output logic             FRAME_SYNC,            // Frame sync output
  input  wire logic [3:0]  GPIO_I,                // Pin levels
  output logic [3:0]       GPIO_O,                // Pin drive values
  output logic [3:0]       GPIO_OE,               // Pin drive enables
  input  wire logic        EXT_OSC_MODE,          // Link pair runs from external oscillator
  output logic [3:0]       REMOTE_GENERAL_OUTPUT, // Pin inputs forwarded to remote side
  input  wire logic [7:0]  S_AXI_AWADDR,          // Write address
  input  wire logic        S_AXI_AWVALID,         // Write address valid
  output logic             S_AXI_AWREADY,         // Write address ready
  input  wire logic [31:0] S_AXI_WDATA,           // Write data
  input  wire logic [3:0]  S_AXI_WSTRB,           // Write byte strobes
  input  wire logic        S_AXI_WVALID,          // Write data valid
  output logic             S_AXI_WREADY,          // Write data ready
  output logic [1:0]       S_AXI_BRESP,           // Write response
  output logic             S_AXI_BVALID,          // Write response valid
  input  wire logic        S_AXI_BREADY,          // Write response ready
  input  wire logic [7:0]  S_AXI_ARADDR,          // Read address
  input  wire logic        S_AXI_ARVALID,         // Read address valid
  output logic             S_AXI_ARREADY,         // Read address ready
  output logic [31:0]      S_AXI_RDATA,           // Read data
  output logic [1:0]       S_AXI_RRESP,           // Read response
  output logic             S_AXI_RVALID,          // Read data valid
  input  wire logic        S_AXI_RREADY           // Read data ready
);

  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : wmerge
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == dspo_pkg::ADDR_CTRL) || (a == dspo_pkg::ADDR_GPIO_DIR) ||
           (a == dspo_pkg::ADDR_GPIO_OUT) || (a == dspo_pkg::ADDR_STATUS);
  endfunction : addr_ok
  // Pixels since the last sync change, saturating
  function automatic logic [3:0] gap_next(input logic [3:0] gap, input logic toggled);
    if (toggled) begin
      return 4'h0;
    end
    return (gap == dspo_pkg::GAP_MAX) ? gap : gap + 4'h1;
  endfunction : gap_next

  logic [7:0]  aw_addr;
  logic [31:0] w_data, status_word, rd_word, next_ctrl, next_dir, next_out;
  logic [3:0]  w_strb, gpio_dir, gpio_out, gpio_s1, gpio_s2, eff_dir;
  logic [3:0]  pdiv_cnt, line_gap, frame_gap;
  logic [1:0]  ctrl_mode;
  logic [13:0] fifo_data;
  logic        aw_held, w_held, do_write, ctrl_edge, ctrl_en;
  logic        underrun, line_viol, frame_viol, clr_under, clr_lviol, clr_fviol;
  logic        ext_s1, ext_s2, pclk_lvl, half_tick, launch, pop, mode10;
  logic        line_tog, frame_tog, fifo_valid, fifo_full, fifo_empty;

  dspo_fifo #(
    .WIDTH (dspo_pkg::WORD_W),
    .DEPTH (dspo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RESET),
    .in_valid  (LINK_VALID),
    .in_ready  (LINK_READY),
    .in_data   ({LINK_FRAME_SYNC, LINK_LINE_SYNC, LINK_PIX_DATA}),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  // AXI write channel: address and data taken in either order
  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY  = !w_held;
  assign do_write      = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= dspo_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= addr_ok(aw_addr) ? dspo_pkg::RESP_OKAY : dspo_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Control and pin registers, merged under the byte strobes
  assign next_ctrl = wmerge({28'h0, ctrl_en, ctrl_mode, ctrl_edge}, w_data, w_strb);
  assign next_dir  = wmerge({28'h0, gpio_dir}, w_data, w_strb);
  assign next_out  = wmerge({28'h0, gpio_out}, w_data, w_strb);
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ctrl_edge <= dspo_pkg::CTRL_EDGE_RESET;
      ctrl_mode <= dspo_pkg::CTRL_MODE_RESET;
      ctrl_en   <= dspo_pkg::CTRL_EN_RESET;
      gpio_dir  <= dspo_pkg::GPIO_DIR_RESET;
      gpio_out  <= dspo_pkg::GPIO_OUT_RESET;
    end else if (do_write) begin
      if (aw_addr == dspo_pkg::ADDR_CTRL) begin
        ctrl_edge <= next_ctrl[dspo_pkg::CTRL_EDGE_BIT];
        ctrl_mode <= next_ctrl[dspo_pkg::CTRL_MODE_LSB +: 2];
        ctrl_en   <= next_ctrl[dspo_pkg::CTRL_EN_BIT];
      end
      if (aw_addr == dspo_pkg::ADDR_GPIO_DIR) begin
        gpio_dir <= next_dir[3:0];
      end
      if (aw_addr == dspo_pkg::ADDR_GPIO_OUT) begin
        gpio_out <= next_out[3:0];
      end
    end
  end

  // Write-one-to-clear of sticky flags; a new event wins over the clear
  assign clr_under = do_write && (aw_addr == dspo_pkg::ADDR_STATUS) && w_strb[0] &&
                     w_data[dspo_pkg::STAT_UNDER_BIT];
  assign clr_lviol = do_write && (aw_addr == dspo_pkg::ADDR_STATUS) && w_strb[1] &&
                     w_data[dspo_pkg::STAT_LVIOL_BIT];
  assign clr_fviol = do_write && (aw_addr == dspo_pkg::ADDR_STATUS) && w_strb[1] &&
                     w_data[dspo_pkg::STAT_FVIOL_BIT];

  // AXI read channel
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[dspo_pkg::STAT_PIN_LSB +: 4]  = gpio_s2;
    status_word[dspo_pkg::STAT_EXTOSC_BIT]    = ext_s2;
    status_word[dspo_pkg::STAT_EMPTY_BIT]     = fifo_empty;
    status_word[dspo_pkg::STAT_FULL_BIT]      = fifo_full;
    status_word[dspo_pkg::STAT_UNDER_BIT]     = underrun;
    status_word[dspo_pkg::STAT_LVIOL_BIT]     = line_viol;
    status_word[dspo_pkg::STAT_FVIOL_BIT]     = frame_viol;
    case (S_AXI_ARADDR)
      dspo_pkg::ADDR_CTRL:     rd_word = {28'h0, ctrl_en, ctrl_mode, ctrl_edge};
      dspo_pkg::ADDR_GPIO_DIR: rd_word = {28'h0, gpio_dir};
      dspo_pkg::ADDR_GPIO_OUT: rd_word = {28'h0, gpio_out};
      dspo_pkg::ADDR_STATUS:   rd_word = status_word;
      default:                 rd_word = 32'h0000_0000;
    endcase
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= dspo_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= addr_ok(S_AXI_ARADDR) ? dspo_pkg::RESP_OKAY : dspo_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Pixel clock divider; data launch on the transition to the non-strobe level
  assign half_tick = (pdiv_cnt == 4'(dspo_pkg::PCLK_HALF - 1));
  assign launch    = half_tick && ((!pclk_lvl) != ctrl_edge);
  assign pop       = launch && ctrl_en && fifo_valid;
  assign mode10    = (ctrl_mode == dspo_pkg::DSPO_MODE_10);
  assign PIXEL_CLK = pclk_lvl;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pdiv_cnt <= 4'h0;
      pclk_lvl <= 1'b0;
    end else if (half_tick) begin
      pdiv_cnt <= 4'h0;
      pclk_lvl <= !pclk_lvl;
    end else begin
      pdiv_cnt <= pdiv_cnt + 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      PIXEL_DATA_OUT <= 12'h000;
      LINE_SYNC      <= 1'b0;
      FRAME_SYNC     <= 1'b0;
    end else if (pop) begin
      // Upper two data lines held low when only ten bits are carried
      PIXEL_DATA_OUT <= mode10 ? {2'h0, fifo_data[dspo_pkg::PIX10_W-1:0]} :
                                 fifo_data[dspo_pkg::PIX_W-1:0];
      LINE_SYNC      <= fifo_data[dspo_pkg::WORD_LINE_BIT];
      FRAME_SYNC     <= fifo_data[dspo_pkg::WORD_FRAME_BIT];
    end
  end

  // Sync spacing monitor; syncs are forwarded regardless, only flagged
  assign line_tog  = pop && (fifo_data[dspo_pkg::WORD_LINE_BIT] != LINE_SYNC);
  assign frame_tog = pop && (fifo_data[dspo_pkg::WORD_FRAME_BIT] != FRAME_SYNC);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      line_gap  <= dspo_pkg::GAP_MAX;
      frame_gap <= dspo_pkg::GAP_MAX;
    end else if (pop) begin
      line_gap  <= gap_next(line_gap, line_tog);
      frame_gap <= gap_next(frame_gap, frame_tog);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      underrun   <= 1'b0;
      line_viol  <= 1'b0;
      frame_viol <= 1'b0;
    end else begin
      // Set terms first: an event in the clearing cycle wins
      underrun   <= (launch && ctrl_en && !fifo_valid) || (underrun && !clr_under);
      line_viol  <= (mode10 && line_tog && (line_gap < 4'(dspo_pkg::SYNC_MIN_PIX - 1))) ||
                    (line_viol && !clr_lviol);
      frame_viol <= (mode10 && frame_tog && (frame_gap < 4'(dspo_pkg::SYNC_MIN_PIX - 1))) ||
                    (frame_viol && !clr_fviol);
    end
  end

  // Pin synchronisers; no reset, so hold reset two clocks for them to settle
  always_ff @(posedge CLK_SYS) begin
    gpio_s1 <= GPIO_I;
    gpio_s2 <= gpio_s1;
    ext_s1  <= EXT_OSC_MODE;
    ext_s2  <= ext_s1;
  end

  // External oscillator overrides the upper pair to outputs
  assign eff_dir = gpio_dir | (ext_s2 ? dspo_pkg::GPIO_UPPER_MASK : 4'h0);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      GPIO_OE               <= 4'h0;
      GPIO_O                <= 4'h0;
      REMOTE_GENERAL_OUTPUT <= 4'h0;
    end else begin
      GPIO_OE               <= eff_dir;
      GPIO_O                <= gpio_out;
      REMOTE_GENERAL_OUTPUT <= gpio_s2 & ~eff_dir;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  property p_raw_sync;
    (pop && !mode10) |=> (LINE_SYNC == $past(fifo_data[12])) &&
                         (FRAME_SYNC == $past(fifo_data[13]));
  endproperty
  a_raw_sync: assert property (p_raw_sync) else $error("sync not passed raw");
  property p_strobe_edge;
    $changed(PIXEL_DATA_OUT) |-> (PIXEL_CLK != $past(ctrl_edge));
  endproperty
  a_strobe_edge: assert property (p_strobe_edge) else $error("data moved on strobe edge");
  property p_fwd_low;
    (!GPIO_OE[0])[*4] |-> (REMOTE_GENERAL_OUTPUT[0] == $past(GPIO_I[0], 3));
  endproperty
  a_fwd_low: assert property (p_fwd_low) else $error("lower pin not forwarded");
  property p_fwd_up;
    (!GPIO_OE[2])[*4] |-> (REMOTE_GENERAL_OUTPUT[2] == $past(GPIO_I[2], 3));
  endproperty
  a_fwd_up: assert property (p_fwd_up) else $error("upper pin not forwarded");
  property p_extosc;
    ext_s2 |=> (GPIO_OE[3:2] == 2'h3) && (REMOTE_GENERAL_OUTPUT[3:2] == 2'h0);
  endproperty
  a_extosc: assert property (p_extosc) else $error("upper pins not forced out");
  property p_pclk_period;
    $rose(PIXEL_CLK) |=> (!$rose(PIXEL_CLK))[*3] ##1 $rose(PIXEL_CLK);
  endproperty
  a_pclk_period: assert property (p_pclk_period) else $error("pixel clock period wrong");
  property p_mask10;
    (pop && mode10) |=> (PIXEL_DATA_OUT[11:10] == 2'h0);
  endproperty
  a_mask10: assert property (p_mask10) else $error("upper data bits set in 10-bit mode");
  property p_gpio_update;
    (do_write && (aw_addr == dspo_pkg::ADDR_GPIO_OUT) && w_strb[0]) |->
      ##2 (GPIO_O == $past(w_data[3:0], 2));
  endproperty
  a_gpio_update: assert property (p_gpio_update) else $error("pin output not updated");

  c_pop:      cover property (pop ##1 $changed(PIXEL_DATA_OUT));
  c_underrun: cover property ($rose(underrun));
  c_extosc:   cover property ($rose(ext_s2) ##1 (GPIO_OE[3:2] == 2'h3));
  c_viol:     cover property ($rose(line_viol));

endmodule : dspo_top

// >>> test/dspo_video_sink.sv
// Downstream video processor model: latches pixel words on the strobe edge.
// Assumes PIXEL_CLK is a registered output sampled on the system clock.
`timescale 1ns/1ps
module dspo_video_sink (
  input  wire logic        clk,       // System clock
  input  wire logic        pclk,      // Pixel clock from block
  input  wire logic        edge_sel,  // High = rising strobe
  input  wire logic [13:0] word,      // Frame, line, data
  output logic             cap_valid, // New word latched
  output logic [13:0]      cap_word   // Latched word
);
  logic        pclk_q;
  logic [13:0] last = 14'h0000;

  // Repeats dropped: an underrun holds the bus, so only a change is a new pixel
  always_ff @(posedge clk) begin
    pclk_q    <= pclk;
    cap_valid <= 1'h0;
    if (pclk != pclk_q && pclk == edge_sel && word != last) begin
      cap_valid <= 1'h1;
      cap_word  <= word;
      last      <= word;
    end
  end
endmodule : dspo_video_sink

// >>> test/tb.sv
// Self-checking bench for the pixel output and general-purpose pin block.
// Assumes the design files and the video sink model are compiled first.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [11:0] pix = 12'h000;
  logic        ls = 1'h0, fs = 1'h0, lv = 1'h0, xo = 1'h0, es = 1'h1;
  logic        lr, pclk, lso, fso, cv, awr, wrd, bv, arr, rv;
  logic [11:0] pdo;
  logic [13:0] cw;
  logic [3:0]  gi = 4'h0, ws = 4'hF, go, goe, rgo;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdt;
  logic [1:0]  br, rr;
  logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [13:0] expq[$];
  int          mismatches = 0, check_count = 0, seq = 1;
  logic [3:0]  ctab[5] = '{4'h9, 4'hA, 4'hF, 4'hD, 4'hC};

  always #5 clk = ~clk;

  dspo_top u_dspo_top (.CLK_SYS(clk), .RESET(rst), .LINK_PIX_DATA(pix),
    .LINK_LINE_SYNC(ls), .LINK_FRAME_SYNC(fs), .LINK_VALID(lv), .LINK_READY(lr),
    .PIXEL_CLK(pclk), .PIXEL_DATA_OUT(pdo), .LINE_SYNC(lso), .FRAME_SYNC(fso),
    .GPIO_I(gi), .GPIO_O(go), .GPIO_OE(goe), .EXT_OSC_MODE(xo),
    .REMOTE_GENERAL_OUTPUT(rgo), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));

  dspo_video_sink u_dspo_video_sink (.clk(clk), .pclk(pclk), .edge_sel(es),
    .word({fso, lso, pdo}), .cap_valid(cv), .cap_word(cw));

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrd) wv <= 1'h0;
    end while (!bv);
    bry <= 1'h0;
    check("bresp", 32'(br), 32'(e));
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a; arv <= 1'h1; rry <= 1'h1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'h0;
    end while (!rv);
    d = rdt;
    r = rr;
    rry <= 1'h0;
  endtask : axr

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    check(n, d & m, e);
  endtask : rdchk

  // Bit 0 follows a global count so every pixel differs from the one before
  task automatic send(input int n, input logic [1:0] mode);
    logic [11:0] d;
    logic        l, f;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      d = 12'($urandom);
      d[0] = seq[0];
      seq++;
      // 10-bit runs toggle every pixel so the spacing flags are sure to set
      l = (mode == 2'h2) ? i[0] : 1'($urandom);
      f = (mode == 2'h2) ? !i[0] : 1'($urandom);
      pix <= d; ls <= l; fs <= f; lv <= 1'h1;
      do @(posedge clk); while (!lr);
      if (mode == 2'h2) d[11:10] = 2'h0;
      expq.push_back({f, l, d});
    end
    lv <= 1'h0;
  endtask : send

  task automatic drain;
    repeat (300) if (expq.size() != 0) @(posedge clk);
    check("queue left", 32'(expq.size()), 32'h0);
  endtask : drain

  always @(posedge clk) begin
    if (cv) begin
      if (expq.size() == 0) check("pixel extra", 32'h1, 32'h0);
      else check("pixel word", 32'(cw), 32'(expq.pop_front()));
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  dir, out, pin;
    void'($urandom(52));
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    rdchk("ctrl reset", dspo_pkg::ADDR_CTRL, 32'hF, 32'h9);
    rdchk("dir reset", dspo_pkg::ADDR_GPIO_DIR, 32'hF, 32'h0);
    axr(8'h10, d, r);
    check("unmapped rresp", 32'(r), 32'(dspo_pkg::RESP_SLVERR));
    axw(8'h10, 32'h1, dspo_pkg::RESP_SLVERR);
    // 12LF on rising, 12HF on falling, 10-bit on both strobe edges, and unused mode 3; sync violations flag only in 10-bit mode
    foreach (ctab[k]) begin
      axw(dspo_pkg::ADDR_CTRL, 32'(ctab[k]), dspo_pkg::RESP_OKAY);
      es <= ctab[k][0];
      send(12, ctab[k][2:1]);
      drain();
      rdchk("sync flags", dspo_pkg::ADDR_STATUS, 32'h300,
            (ctab[k][2:1] == 2'h2) ? 32'h300 : 32'h0);
      axw(dspo_pkg::ADDR_STATUS, 32'h300, dspo_pkg::RESP_OKAY);
    end
    rdchk("sync cleared", dspo_pkg::ADDR_STATUS, 32'h300, 32'h0);
    // Output disabled: buffer fills until it refuses, then drains
    axw(dspo_pkg::ADDR_CTRL, 32'h1, dspo_pkg::RESP_OKAY);
    es <= 1'h1;
    send(16, 2'h0);
    repeat (2) @(posedge clk);
    check("ready when full", 32'(lr), 32'h0);
    rdchk("status full", dspo_pkg::ADDR_STATUS, 32'h60, 32'h40);
    axw(dspo_pkg::ADDR_CTRL, 32'h9, dspo_pkg::RESP_OKAY);
    drain();
    rdchk("status empty", dspo_pkg::ADDR_STATUS, 32'hE0, 32'hA0);
    for (int k = 0; k < 4; k++) begin
      dir = (k == 0) ? 4'h3 : 4'($urandom);
      out = 4'($urandom);
      pin = 4'($urandom);
      xo <= (k >= 2);
      gi <= pin;
      axw(dspo_pkg::ADDR_GPIO_DIR, 32'(dir), dspo_pkg::RESP_OKAY);
      axw(dspo_pkg::ADDR_GPIO_OUT, 32'(out), dspo_pkg::RESP_OKAY);
      repeat (4) @(posedge clk);
      check("gpio out", 32'(go), 32'(out));
      if (k >= 2) dir = dir | dspo_pkg::GPIO_UPPER_MASK;
      check("gpio enable", 32'(goe), 32'(dir));
      check("remote out", 32'(rgo), 32'(pin & ~dir));
      rdchk("pin status", dspo_pkg::ADDR_STATUS, 32'h1F, 32'({1'(k >= 2), pin}));
    end
    results();
  end

  // Whole sequence needs several hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : tb
